/* File: include/fsg_pkg.sv */
// fsg_pkg: constants and carrier types for the flash security guard
// assumes a single core_clk domain and a flash sequencer that executes granted commands
package fsg_pkg;
   localparam int ADDR_W = 16;
   localparam logic [15:0] BOOT_LO = 16'h0000;
   localparam logic [15:0] BOOT_HI = 16'h0fff;
   localparam int SEC_W = 4;
   localparam int BIT_CHIP = 0;
   localparam int BIT_BLK = 1;
   localparam int BIT_WR = 2;
   localparam int BIT_BOOT = 3;
   localparam logic [3:0] SEC_SHIPPED = 4'h0;

   typedef enum logic [2:0]
   {
      FSG_CMD_CHIP_ERASE = 3'h1,
      FSG_CMD_BLK_ERASE = 3'h2,
      FSG_CMD_WRITE = 3'h4
   } fsg_op_t;

   typedef struct packed
   {
      logic valid;
      logic self_prog;
      fsg_op_t op;
      logic [ADDR_W-1:0] addr;
   } fsg_cmd_t;

   typedef struct packed
   {
      logic valid;
      logic granted;
      logic refused;
      logic [SEC_W-1:0] cause;
   } fsg_resp_t;
endpackage

/* File: rtl/fsg_guard.sv */
// fsg_guard: checks erase and write commands against four security settings
// assumes nonvolatile storage outside holds the settings; nv_sec is loaded at reset release
`timescale 1ns/10ps
// Operation
// R1: new settings take effect only at next programming-mode entry
// R2: chip-erase lock refuses chip and block erase from external programmer
// R3: once chip-erase lock is set, no setting can ever be cleared
// R4: with chip-erase lock no erase happens, so writes cannot alter contents; code still grants block erase from self programming
// R5: block-erase lock refuses external block erase
// R6: block-erase lock does not restrict self programming
// R7: write lock refuses external write and block erase
// R8: write lock does not restrict self programming
// R9: boot lock refuses block erase and write into 0000h..0fffh
// R10: boot lock also refuses chip erase
// R11: shipped state has all four locks inactive
// R12: settings come from programmer or self programming, any combination
// R13: a completed chip erase clears every setting; code clears nothing while the pending chip-erase lock is set
// R14: settings persist in nonvolatile storage; refused commands report an error
module fsg_guard
   import fsg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [SEC_W-1:0] nv_sec,
   input wire logic prog_entry,
   input wire fsg_cmd_t cmd,
   input wire logic sec_set_valid,
   input wire logic [SEC_W-1:0] sec_set_val,
   input wire logic chip_erase_done,
   output fsg_resp_t resp_q,
   output logic [SEC_W-1:0] sec_active_q,
   output logic [SEC_W-1:0] sec_pending_q,
   output logic nv_wr_q
);
   logic loaded_q;
   logic req_ok;
   logic [SEC_W-1:0] why_d;

   function automatic logic in_boot(input logic [ADDR_W-1:0] a);
      in_boot = (a >= BOOT_LO) && (a <= BOOT_HI);
   endfunction

   // command from the programmer rather than from self programming
   function automatic logic from_outside(input fsg_cmd_t c);
      from_outside = !c.self_prog;
   endfunction

   // stored settings are taken once, on the first edge after reset
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         loaded_q <= 1'h0;
      end
      else
      begin
         loaded_q <= 1'h1;
      end
   end

   // pending value mirrors nonvolatile storage
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         sec_pending_q <= SEC_SHIPPED; // [R11]
      end
      else if (!loaded_q)
      begin
         sec_pending_q <= nv_sec; // [R14]
      end
      else if (chip_erase_done && !sec_pending_q[BIT_CHIP])
      begin
         sec_pending_q <= SEC_SHIPPED; // [R13]
      end
      else if (sec_set_valid)
      begin
         sec_pending_q <= sec_pending_q | sec_set_val; // [R3] [R12]
      end
   end

   // store strobe whenever a set or a chip-erase clear rewrote the pending value, not on the load from nv_sec
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         nv_wr_q <= 1'h0;
      end
      else if (!loaded_q)
      begin
         nv_wr_q <= 1'h0;
      end
      else
      begin
         nv_wr_q <= (chip_erase_done && !sec_pending_q[BIT_CHIP]) || sec_set_valid; // [R14]
      end
   end

   // active copy only follows at programming-mode entry
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         sec_active_q <= SEC_SHIPPED;
      else if (!loaded_q)
         sec_active_q <= nv_sec;
      else if (prog_entry)
         sec_active_q <= sec_pending_q; // [R1]
   end

   // a request counts once the stored settings are in
   assign req_ok = cmd.valid && loaded_q;

   // refusal causes, one bit per setting that stops the command
   always_comb
   begin
      why_d = '0;
      if (req_ok)
      begin
         case (cmd.op)
            FSG_CMD_CHIP_ERASE:
            begin
               why_d[BIT_CHIP] = sec_active_q[BIT_CHIP]; // [R2] [R4]
               why_d[BIT_BOOT] = sec_active_q[BIT_BOOT]; // [R10]
            end
            FSG_CMD_BLK_ERASE:
            begin
               why_d[BIT_CHIP] = sec_active_q[BIT_CHIP] && from_outside(cmd); // [R2] [R4]
               why_d[BIT_BLK] = sec_active_q[BIT_BLK] && from_outside(cmd); // [R5] [R6]
               why_d[BIT_WR] = sec_active_q[BIT_WR] && from_outside(cmd); // [R7]
               why_d[BIT_BOOT] = sec_active_q[BIT_BOOT] && in_boot(cmd.addr); // [R9]
            end
            FSG_CMD_WRITE:
            begin
               why_d[BIT_WR] = sec_active_q[BIT_WR] && from_outside(cmd); // [R7] [R8]
               why_d[BIT_BOOT] = sec_active_q[BIT_BOOT] && in_boot(cmd.addr); // [R9]
            end
            default:
            begin
               why_d = '0;
            end
         endcase
      end
   end

   // answer one cycle after the request
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         resp_q <= '0;
      end
      else
      begin
         resp_q.valid <= req_ok;
         resp_q.granted <= req_ok && (why_d == '0);
         resp_q.refused <= req_ok && (why_d != '0); // [R14]
         resp_q.cause <= why_d;
      end
   end

   // command checks
   AST_CHIP_REFUSED: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
      cmd.valid && loaded_q && cmd.op == FSG_CMD_CHIP_ERASE
      && (sec_active_q[BIT_CHIP] || sec_active_q[BIT_BOOT]) |=> resp_q.refused)
      else $error("chip erase granted while locked");

   AST_NO_ERASE: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
      req_ok && from_outside(cmd) && cmd.op != FSG_CMD_WRITE && sec_active_q[BIT_CHIP]
      |=> resp_q.refused && resp_q.cause[BIT_CHIP])
      else $error("erase granted under chip lock");

   AST_BLK_EXT: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
      cmd.valid && loaded_q && !cmd.self_prog && cmd.op == FSG_CMD_BLK_ERASE
      && (sec_active_q[BIT_BLK] || sec_active_q[BIT_WR]) |=> resp_q.refused)
      else $error("external block erase granted");

   AST_SELF_BLK: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
      req_ok && !from_outside(cmd) && cmd.op == FSG_CMD_BLK_ERASE
      && !sec_active_q[BIT_BOOT] |=> resp_q.granted)
      else $error("self block erase refused");

   AST_WR_EXT: assert property (@(posedge core_clk) disable iff (!rst_b) // [R7]
      req_ok && from_outside(cmd) && cmd.op == FSG_CMD_WRITE && sec_active_q[BIT_WR]
      |=> resp_q.refused && resp_q.cause[BIT_WR])
      else $error("external write granted under write lock");

   AST_SELF_OK: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
      cmd.valid && loaded_q && cmd.self_prog && cmd.op == FSG_CMD_WRITE
      && !sec_active_q[BIT_BOOT] |=> resp_q.granted)
      else $error("self write refused");

   AST_BOOT: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
      cmd.valid && loaded_q && cmd.op == FSG_CMD_WRITE && sec_active_q[BIT_BOOT]
      && cmd.addr <= BOOT_HI |=> resp_q.refused && resp_q.cause[BIT_BOOT])
      else $error("boot write granted");

   AST_EXCL: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
      req_ok |=> resp_q.valid && (resp_q.granted != resp_q.refused))
      else $error("request without a single answer");

   // settings store
   AST_LOCK_STICKY: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
      loaded_q && sec_pending_q[BIT_CHIP] && $past(loaded_q) |=> sec_pending_q[BIT_CHIP]
      && ($past(sec_pending_q) & ~sec_pending_q) == '0)
      else $error("setting cleared under chip lock");

   AST_DEFERRED: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
      loaded_q && !prog_entry |=> $stable(sec_active_q))
      else $error("active settings changed outside entry");

   AST_ENTRY_COPY: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
      loaded_q && prog_entry |=> sec_active_q == $past(sec_pending_q))
      else $error("entry did not apply pending settings");

   AST_SET_OR: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
      loaded_q && sec_set_valid && !chip_erase_done
      |=> (sec_pending_q & $past(sec_set_val)) == $past(sec_set_val) && nv_wr_q)
      else $error("set command not stored");

   AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13]
      loaded_q && chip_erase_done && !sec_pending_q[BIT_CHIP]
      |=> sec_pending_q == SEC_SHIPPED && nv_wr_q)
      else $error("chip erase did not clear settings");

   // scenario covers
   COV_REFUSE: cover property (@(posedge core_clk) disable iff (!rst_b) resp_q.refused);
   COV_GRANT: cover property (@(posedge core_clk) disable iff (!rst_b) resp_q.granted);
   COV_ENTRY: cover property (@(posedge core_clk) disable iff (!rst_b)
      sec_set_valid ##[1:20] prog_entry);
   COV_CLEAR: cover property (@(posedge core_clk) disable iff (!rst_b)
      loaded_q && chip_erase_done && !sec_pending_q[BIT_CHIP]);
   COV_STUCK: cover property (@(posedge core_clk) disable iff (!rst_b)
      loaded_q && chip_erase_done && sec_pending_q[BIT_CHIP]);
endmodule // fsg_guard

/* File: sim/fsg_seq_model.sv */
// fsg_seq_model: sequencer stand-in that finishes each granted chip erase
// assumes the driver holds cmd.op after its request pulse
`timescale 1ns/10ps
module fsg_seq_model
   import fsg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire fsg_resp_t resp_q,
   input wire fsg_op_t op,
   output logic chip_erase_done
);
   always_ff @(posedge core_clk)
   begin
      chip_erase_done <= rst_b && resp_q.valid && resp_q.granted && op == FSG_CMD_CHIP_ERASE;
   end
endmodule // fsg_seq_model

/* File: sim/flash_security_guard_tb.sv */
// flash_security_guard_tb: table of guarded commands, then session tests
// assumes fsg_guard and fsg_seq_model are compiled with fsg_pkg
`timescale 1ns/10ps
module flash_security_guard_tb
   import fsg_pkg::*;
;
   typedef struct packed
   {
      logic [3:0] sec;
      logic slf;
      fsg_op_t op;
      logic [15:0] a;
      logic [3:0] cs;
   } fsg_row_t;
   fsg_row_t rows [13] = '{
      '{4'h0, 1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h0},
      '{4'h1, 1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h1},
      '{4'h1, 1'b0, FSG_CMD_BLK_ERASE, 16'h2000, 4'h1},
      '{4'h2, 1'b0, FSG_CMD_BLK_ERASE, 16'h2000, 4'h2},
      '{4'h2, 1'b1, FSG_CMD_BLK_ERASE, 16'h2000, 4'h0},
      '{4'h4, 1'b0, FSG_CMD_WRITE, 16'h2000, 4'h4},
      '{4'h4, 1'b0, FSG_CMD_BLK_ERASE, 16'h2000, 4'h4},
      '{4'h4, 1'b1, FSG_CMD_WRITE, 16'h2000, 4'h0},
      '{4'h8, 1'b1, FSG_CMD_WRITE, 16'h0fff, 4'h8},
      '{4'h8, 1'b0, FSG_CMD_WRITE, 16'h1000, 4'h0},
      '{4'h8, 1'b1, FSG_CMD_BLK_ERASE, 16'h0800, 4'h8},
      '{4'hf, 1'b0, FSG_CMD_WRITE, 16'h0100, 4'hc},
      '{4'h8, 1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h8}};
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] nv_sec = 4'h0;
   logic prog_entry = 1'b0;
   fsg_cmd_t cmd = '0;
   logic sec_set_valid = 1'b0;
   logic [3:0] sec_set_val = 4'h0;
   logic chip_erase_done;
   fsg_resp_t resp_q;
   logic [3:0] sec_active_q;
   logic [3:0] sec_pending_q;
   logic nv_wr_q;
   int errors = 0;
   int cmp_count = 0;
   always #2.5 core_clk = ~core_clk;
   fsg_guard fsg_guard_i (.core_clk(core_clk), .rst_b(rst_b), .nv_sec(nv_sec),
      .prog_entry(prog_entry), .cmd(cmd), .sec_set_valid(sec_set_valid),
      .sec_set_val(sec_set_val), .chip_erase_done(chip_erase_done), .resp_q(resp_q),
      .sec_active_q(sec_active_q), .sec_pending_q(sec_pending_q), .nv_wr_q(nv_wr_q));
   fsg_seq_model fsg_seq_model_i (.core_clk(core_clk), .rst_b(rst_b), .resp_q(resp_q),
      .op(cmd.op), .chip_erase_done(chip_erase_done));
   task stop_test;
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task rst(input logic [3:0] s);
      @(posedge core_clk) rst_b <= 1'b0;
      nv_sec <= s;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1;
   endtask
   task issue(input logic slf, input fsg_op_t op, input logic [15:0] a, input logic [3:0] cs);
      @(posedge core_clk) cmd <= '{1'b1, slf, op, a};
      @(posedge core_clk) cmd.valid <= 1'b0;
      #1 chk("resp", {2'b01, cs == 4'h0, cs != 4'h0},
         {1'b0, resp_q.valid, resp_q.granted, resp_q.refused});
      chk("cause", cs, resp_q.cause);
   endtask
   task set_sec(input logic [3:0] v);
      @(posedge core_clk) sec_set_valid <= 1'b1;
      sec_set_val <= v;
      @(posedge core_clk) sec_set_valid <= 1'b0;
      #1;
   endtask
   task enter;
      @(posedge core_clk) prog_entry <= 1'b1;
      @(posedge core_clk) prog_entry <= 1'b0;
      #1;
   endtask
   initial
   begin
      #60000 errors++;
      stop_test;
   end
   initial
   begin
      rst(4'h0);
      chk("active", 4'h0, sec_active_q);
      foreach (rows[i])
      begin
         rst(rows[i].sec);
         issue(rows[i].slf, rows[i].op, rows[i].a, rows[i].cs);
      end
      rst(4'h0);
      set_sec(4'h4);
      chk("pending", 4'h4, sec_pending_q);
      chk("nv_wr", 4'h1, {3'h0, nv_wr_q});
      issue(1'b0, FSG_CMD_WRITE, 16'h2000, 4'h0);
      enter;
      issue(1'b0, FSG_CMD_WRITE, 16'h2000, 4'h4);
      issue(1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h0);
      repeat (2) @(posedge core_clk);
      #1 chk("pending", 4'h0, sec_pending_q);
      chk("nv_wr", 4'h1, {3'h0, nv_wr_q});
      enter;
      chk("active", 4'h0, sec_active_q);
      set_sec(4'h1);
      issue(1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h0);
      repeat (2) @(posedge core_clk);
      #1 chk("pending", 4'h1, sec_pending_q);
      chk("nv_wr", 4'h0, {3'h0, nv_wr_q});
      rst(4'h1);
      set_sec(4'ha);
      chk("pending", 4'hb, sec_pending_q);
      issue(1'b0, FSG_CMD_CHIP_ERASE, 16'h0000, 4'h1);
      enter;
      chk("active", 4'hb, sec_active_q);
      stop_test;
   end
endmodule // flash_security_guard_tb
